// *** src/tpg_cfg.svh ***
`ifndef TPG_CFG_SVH
`define TPG_CFG_SVH
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define TPG_CLK_NS        4
`define TPG_DT_STEP_NS    50
`define TPG_DT_STEP_CYC   ((`TPG_DT_STEP_NS + `TPG_CLK_NS - 1) / `TPG_CLK_NS)
`define TPG_DT_MAX_NS     12000
`define TPG_DT_MAX_STEPS  (`TPG_DT_MAX_NS / `TPG_DT_STEP_NS)
`define TPG_DT_W          12
`define TPG_SCLK_NS       333
`define TPG_SCLK_HALF_CYC ((`TPG_SCLK_NS + 2 * `TPG_CLK_NS - 1) / (2 * `TPG_CLK_NS))
`define TPG_CS_EDGE_NS    100
`define TPG_CS_EDGE_CYC   ((`TPG_CS_EDGE_NS + `TPG_CLK_NS - 1) / `TPG_CLK_NS)
`define TPG_CS_GAP_NS     200
`define TPG_CS_GAP_CYC    ((`TPG_CS_GAP_NS + `TPG_CLK_NS - 1) / `TPG_CLK_NS)
// ---------------------------------------------------------------
// Serial frame: opcode in [15:12], argument in [7:0]
// ---------------------------------------------------------------
`define TPG_FRAME_BITS    16
`define TPG_OP_STATUS     4'h0
`define TPG_OP_MASK_LO    4'h1
`define TPG_OP_MASK_HI    4'h2
`define TPG_OP_DEADTIME   4'h3
`define TPG_OP_MODE       4'h4
`define TPG_OP_CLR_INT    4'h5
`define TPG_MASK_RST      4'hF
`define TPG_DT_RST        8'h02
// ---------------------------------------------------------------
// Controller command port
// ---------------------------------------------------------------
`define TPG_H_CTRL        8'h00
`define TPG_H_REQ         8'h04
`define TPG_H_TX          8'h08
`define TPG_H_RX          8'h0C
`define TPG_H_STAT        8'h10
`endif

// *** src/tpg_device.sv ***
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tpg_cfg.svh"
// Function
// - Gates on only with both enables high
// - Low enable leaves logic and serial port running
// - High side waits for one low-side pulse
// - Reset holds gates off with pull-down
// - Logic reset within 77 ns
// - Reset switches off logic supply regulator
// - Below power-on threshold: reset, tri-state, deaf
// - Position output follows half-supply comparison
// - High-side requests active low, idle high
// - Low-side requests active high, idle low
// - Interlock and deadtime by default, overridable
// - Fault sets interrupt until clear command
// - Two mask registers gate fault sources
// - Serial port answers only while selected
// - Input sampled on falling clock, MSB first
// - Output hi-Z unselected, shifts on rising
// - Serial clock typically 3 MHz, max 5
// - Over-current flag follows the condition
// - Deadtime programmable in 50 ns steps
// - Simultaneous-mode command accepted once per reset
module tpg_device
   import tpg_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   tpg_if.device           link,
   input  wire logic       por_ok,
   input  wire logic [2:0] hs_src_above_half,
   input  wire logic       overcurrent_in,
   input  wire logic [6:0] fault_in,
   output logic [2:0]      gate_high,
   output logic [2:0]      gate_low,
   output logic            gate_pulldown,
   output logic            gate_hiz,
   output logic            vdd_reg_en
);
   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   tpg_pins_t                     raw;
   tpg_pins_t                     s1_q;
   tpg_pins_t                     p;
   logic                          arst_n;
   logic                          en_raw;
   logic                          en_s;
   logic [2:0]                    high_q;
   logic [2:0]                    low_q;
   logic [2:0]                    high_d;
   logic [2:0]                    low_d;
   logic [2:0]                    armed_q;
   logic [`TPG_DT_W-1:0]          dt_q [3];
   logic [7:0]                    dt_steps_q;
   logic [3:0]                    mask_low_q;
   logic [3:0]                    mask_high_q;
   logic                          simul_q;
   logic                          mode_locked_q;
   logic [7:0]                    pending_q;
   logic                          int_q;
   logic [7:0]                    fault_src;
   logic [`TPG_FRAME_BITS-1:0]    status;
   logic [`TPG_FRAME_BITS-1:0]    rx_word;
   logic                          rx_valid;
   logic [3:0]                    op;
   logic [7:0]                    arg;
   logic                          clr_int;

   function automatic logic [`TPG_DT_W-1:0] dt_cycles(input logic [7:0] steps);
      dt_cycles = `TPG_DT_W'(steps * `TPG_DT_STEP_CYC);
   endfunction

   // ---------------------------------------------------------------
   // Reset, power and gate output stage
   // ---------------------------------------------------------------
   // Asynchronous so the logic is cleared well inside 77 ns of the pin
   assign arst_n        = rst_n & link.dev_reset_n & por_ok;
   assign vdd_reg_en    = link.dev_reset_n;
   assign gate_pulldown = ~link.dev_reset_n;
   assign gate_hiz      = ~por_ok;
   // Raw enables act without any clock edge
   assign en_raw        = link.enable_a_in & link.enable_b_in & link.dev_reset_n & por_ok;
   assign gate_high     = high_q & {3{en_raw}};
   assign gate_low      = low_q & {3{en_raw}};

   // ---------------------------------------------------------------
   // Pin synchronisers, polarity folded so reset value is idle
   // ---------------------------------------------------------------
   always_comb
   begin
      raw            = '0;
      raw.en_a       = link.enable_a_in;
      raw.en_b       = link.enable_b_in;
      raw.high_req   = ~{link.phase_c_high_req_n, link.phase_b_high_req_n,
                         link.phase_a_high_req_n};
      raw.low_req    = {link.phase_c_low_req, link.phase_b_low_req,
                        link.phase_a_low_req};
      raw.above_half = hs_src_above_half;
      raw.oc         = overcurrent_in;
      raw.fault      = fault_in;
      raw.cs         = ~link.cs_n;
      raw.sclk       = link.sclk;
      raw.sdi        = link.sdi;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s1_q <= '0;
         p    <= '0;
      end
      else
      begin
         s1_q <= raw;
         p    <= s1_q;
      end
   end

   assign en_s = p.en_a & p.en_b;

   assign link.phase_a_position_out = p.above_half[0];
   assign link.phase_b_position_out = p.above_half[1];
   assign link.phase_c_position_out = p.above_half[2];
   assign link.overcurrent_flag_out = p.oc;
   assign link.interrupt_out        = int_q;

   // ---------------------------------------------------------------
   // Phase arbitration
   // ---------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < 3; i++)
      begin
         if (simul_q)
         begin
            // Override: no interlock and no blanking
            high_d[i] = p.high_req[i] & en_s & armed_q[i];
            low_d[i]  = p.low_req[i] & en_s;
         end
         else
         begin
            // Contradicting requests turn both sides off
            high_d[i] = p.high_req[i] & ~p.low_req[i] & en_s & armed_q[i]
                        & ~low_q[i] & (dt_q[i] == '0);
            low_d[i]  = p.low_req[i] & ~p.high_req[i] & en_s
                        & ~high_q[i] & (dt_q[i] == '0);
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         high_q <= '0;
         low_q  <= '0;
         for (int i = 0; i < 3; i++)
            dt_q[i] <= '0;
      end
      else
      begin
         high_q <= high_d;
         low_q  <= low_d;
         for (int i = 0; i < 3; i++)
         begin
            if (!simul_q && ((high_q[i] && !high_d[i]) || (low_q[i] && !low_d[i])))
               dt_q[i] <= dt_cycles(dt_steps_q);
            else if (dt_q[i] != '0)
               dt_q[i] <= dt_q[i] - 1'b1;
         end
      end
   end

   // Bootstrap charge: a disable forgets it, a low-side pulse restores it
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         armed_q <= '0;
      else if (!en_s)
         armed_q <= '0;
      else
         armed_q <= armed_q | low_q;
   end

   // ---------------------------------------------------------------
   // Serial port and configuration
   // ---------------------------------------------------------------
   assign status = {pending_q, mode_locked_q, simul_q, armed_q, p.above_half};

   // Keeps running while enables are low: only arst_n clears it
   tpg_spi_slave #(
      .BITS(`TPG_FRAME_BITS)
   ) u_spi (
      .clk      (clk),
      .arst_n   (arst_n),
      .cs       (p.cs),
      .sclk     (p.sclk),
      .sdi      (p.sdi),
      .tx_word  (status),
      .rx_word  (rx_word),
      .rx_valid (rx_valid),
      .sdo      (link.sdo),
      .sdo_oe_n (link.sdo_oe_n)
   );

   assign op      = rx_word[15:12];
   assign arg     = rx_word[7:0];
   assign clr_int = rx_valid & (op == `TPG_OP_CLR_INT);

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mask_low_q    <= `TPG_MASK_RST;
         mask_high_q   <= `TPG_MASK_RST;
         dt_steps_q    <= `TPG_DT_RST;
         simul_q       <= 1'b0;
         mode_locked_q <= 1'b0;
      end
      else if (rx_valid)
      begin
         unique case (op)
            `TPG_OP_MASK_LO:
               mask_low_q <= arg[3:0];
            `TPG_OP_MASK_HI:
               mask_high_q <= arg[3:0];
            `TPG_OP_DEADTIME:
               // Steps above the 12 us span are clipped
               dt_steps_q <= (arg > 8'(`TPG_DT_MAX_STEPS)) ? 8'(`TPG_DT_MAX_STEPS) : arg;
            `TPG_OP_MODE:
               if (!mode_locked_q)
               begin
                  simul_q       <= arg[0];
                  mode_locked_q <= 1'b1;
               end
            default:
               ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Fault latching; a new fault wins over a clear in the same cycle
   // ---------------------------------------------------------------
   assign fault_src = {p.fault, p.oc};

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pending_q <= '0;
         int_q     <= 1'b0;
      end
      else
      begin
         pending_q <= (pending_q & ~{8{clr_int}})
                      | (fault_src & {mask_high_q, mask_low_q});
         int_q     <= |pending_q;
      end
   end
endmodule
`default_nettype wire

// *** src/tpg_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tpg_cfg.svh"
module tpg_host
   import tpg_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   tpg_if.host              link,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [31:0]      rdata
);
   localparam logic [7:0] HALF = 8'(`TPG_SCLK_HALF_CYC);
   localparam logic [7:0] EDGE = 8'(`TPG_CS_EDGE_CYC);
   localparam logic [7:0] GAP  = 8'(`TPG_CS_GAP_CYC);

   tpg_hstate_t st_q;
   logic [2:0]  ctrl_q;
   logic [2:0]  req_high_q;
   logic [2:0]  req_low_q;
   logic [2:0]  armed_q;
   logic [7:0]  tim_q;
   logic [4:0]  bits_q;
   logic [15:0] tx_q;
   logic [15:0] rx_sh_q;
   logic [15:0] rx_q;
   logic        cs_q;
   logic        sclk_q;
   logic        sdi_q;
   logic [5:0]  s1_q;
   logic [5:0]  s2_q;
   logic        en_both;

   assign en_both = ctrl_q[0] & ctrl_q[1];

   assign link.enable_a_in        = ctrl_q[0];
   assign link.enable_b_in        = ctrl_q[1];
   assign link.dev_reset_n        = ctrl_q[2];
   assign link.phase_a_high_req_n = ~(req_high_q[0] & armed_q[0]);
   assign link.phase_b_high_req_n = ~(req_high_q[1] & armed_q[1]);
   assign link.phase_c_high_req_n = ~(req_high_q[2] & armed_q[2]);
   assign link.phase_a_low_req    = req_low_q[0];
   assign link.phase_b_low_req    = req_low_q[1];
   assign link.phase_c_low_req    = req_low_q[2];
   assign link.cs_n               = ~cs_q;
   assign link.sclk               = sclk_q;
   assign link.sdi                = sdi_q;

   // ---------------------------------------------------------------
   // Device pins into this clock domain
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_q <= '0;
         s2_q <= '0;
      end
      else
      begin
         s1_q <= {link.sdo_line, link.interrupt_out, link.overcurrent_flag_out,
                  link.phase_c_position_out, link.phase_b_position_out,
                  link.phase_a_position_out};
         s2_q <= s1_q;
      end
   end

   // ---------------------------------------------------------------
   // Command port
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_q     <= '0;
         req_high_q <= '0;
         req_low_q  <= '0;
      end
      else if (wr && addr == `TPG_H_CTRL)
         ctrl_q <= wdata[2:0];
      else if (wr && addr == `TPG_H_REQ)
      begin
         req_high_q <= wdata[2:0];
         req_low_q  <= wdata[5:3];
      end
   end

   // High side held back until its low side has been pulsed since enable
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         armed_q <= '0;
      else if (!en_both || !ctrl_q[2])
         armed_q <= '0;
      else
         armed_q <= armed_q | req_low_q;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata <= '0;
      else if (rd)
      begin
         unique case (addr)
            `TPG_H_CTRL: rdata <= {29'h0, ctrl_q};
            `TPG_H_REQ:  rdata <= {26'h0, req_low_q, req_high_q};
            `TPG_H_RX:   rdata <= {16'h0, rx_q};
            `TPG_H_STAT: rdata <= {26'h0, s2_q[4:0], st_q != HS_IDLE};
            default:     rdata <= '0;
         endcase
      end
      else
         rdata <= '0;
   end

   // ---------------------------------------------------------------
   // Serial master; a frame request while busy is dropped
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q    <= HS_IDLE;
         tim_q   <= '0;
         bits_q  <= '0;
         tx_q    <= '0;
         rx_sh_q <= '0;
         rx_q    <= '0;
         cs_q    <= 1'b0;
         sclk_q  <= 1'b0;
         sdi_q   <= 1'b0;
      end
      else if (st_q == HS_IDLE)
      begin
         if (wr && addr == `TPG_H_TX)
         begin
            tx_q   <= wdata[15:0];
            cs_q   <= 1'b1;
            bits_q <= '0;
            tim_q  <= EDGE;
            st_q   <= HS_LEAD;
         end
      end
      else if (tim_q != '0)
         tim_q <= tim_q - 1'b1;
      else
      begin
         unique case (st_q)
            HS_LEAD, HS_LOW:
            begin
               sclk_q <= 1'b1;
               sdi_q  <= tx_q[15];
               tx_q   <= {tx_q[14:0], 1'b0};
               tim_q  <= HALF;
               st_q   <= HS_HIGH;
            end
            HS_HIGH:
            begin
               sclk_q  <= 1'b0;
               rx_sh_q <= {rx_sh_q[14:0], s2_q[5]};
               bits_q  <= bits_q + 1'b1;
               tim_q   <= (bits_q == 5'(`TPG_FRAME_BITS - 1)) ? EDGE : HALF;
               st_q    <= (bits_q == 5'(`TPG_FRAME_BITS - 1)) ? HS_LAG : HS_LOW;
            end
            HS_LAG:
            begin
               cs_q  <= 1'b0;
               tim_q <= GAP;
               st_q  <= HS_GAP;
            end
            HS_GAP:
            begin
               rx_q <= rx_sh_q;
               st_q <= HS_IDLE;
            end
            default:
               st_q <= HS_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// *** src/tpg_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface tpg_if;
   logic enable_a_in;
   logic enable_b_in;
   logic dev_reset_n;
   logic phase_a_high_req_n;
   logic phase_b_high_req_n;
   logic phase_c_high_req_n;
   logic phase_a_low_req;
   logic phase_b_low_req;
   logic phase_c_low_req;
   logic phase_a_position_out;
   logic phase_b_position_out;
   logic phase_c_position_out;
   logic overcurrent_flag_out;
   logic interrupt_out;
   logic cs_n;
   logic sclk;
   logic sdi;
   logic sdo;
   logic sdo_oe_n;
   logic sdo_line;

   // Undriven serial output reads as low
   assign sdo_line = sdo_oe_n ? 1'b0 : sdo;

   modport device (
      input  enable_a_in, enable_b_in, dev_reset_n,
      input  phase_a_high_req_n, phase_b_high_req_n, phase_c_high_req_n,
      input  phase_a_low_req, phase_b_low_req, phase_c_low_req,
      input  cs_n, sclk, sdi,
      output phase_a_position_out, phase_b_position_out, phase_c_position_out,
      output overcurrent_flag_out, interrupt_out, sdo, sdo_oe_n
   );
   modport host (
      output enable_a_in, enable_b_in, dev_reset_n,
      output phase_a_high_req_n, phase_b_high_req_n, phase_c_high_req_n,
      output phase_a_low_req, phase_b_low_req, phase_c_low_req,
      output cs_n, sclk, sdi,
      input  phase_a_position_out, phase_b_position_out, phase_c_position_out,
      input  overcurrent_flag_out, interrupt_out, sdo_line
   );
endinterface
`default_nettype wire

// *** src/tpg_pkg.sv ***
`default_nettype none
package tpg_pkg;
   // Pins seen by the device after two-flop synchronisation
   typedef struct packed {
      logic       en_a;
      logic       en_b;
      logic [2:0] high_req;
      logic [2:0] low_req;
      logic [2:0] above_half;
      logic       oc;
      logic [6:0] fault;
      logic       cs;
      logic       sclk;
      logic       sdi;
   } tpg_pins_t;

   typedef enum logic [2:0] {HS_IDLE, HS_LEAD, HS_HIGH, HS_LOW, HS_LAG, HS_GAP} tpg_hstate_t;
endpackage
`default_nettype wire

// *** src/tpg_spi_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tpg_cfg.svh"
module tpg_spi_slave #(
   parameter int BITS = `TPG_FRAME_BITS
) (
   input  wire logic            clk,
   input  wire logic            arst_n,
   input  wire logic            cs,
   input  wire logic            sclk,
   input  wire logic            sdi,
   input  wire logic [BITS-1:0] tx_word,
   output logic [BITS-1:0]      rx_word,
   output logic                 rx_valid,
   output logic                 sdo,
   output logic                 sdo_oe_n
);
   localparam int CW = $clog2(BITS + 1);

   logic            sclk_q;
   logic            cs_q;
   logic [CW-1:0]   cnt_q;
   logic [BITS-1:0] tx_q;
   logic            rise;
   logic            fall;

   assign rise = sclk & ~sclk_q;
   assign fall = ~sclk & sclk_q;
   assign sdo_oe_n = ~cs;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sclk_q <= 1'b0;
         cs_q   <= 1'b0;
      end
      else
      begin
         sclk_q <= sclk;
         cs_q   <= cs;
      end
   end

   // ---------------------------------------------------------------
   // Receive on falling edges, most significant bit first
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rx_word <= '0;
         cnt_q   <= '0;
      end
      else if (!cs)
         cnt_q <= '0;
      else if (fall)
      begin
         rx_word <= {rx_word[BITS-2:0], sdi};
         // Counting one past BITS marks an over-long frame as invalid
         if (cnt_q != CW'(BITS + 1))
            cnt_q <= cnt_q + 1'b1;
      end
   end

   // A frame counts only if exactly BITS falling edges came inside select
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         rx_valid <= 1'b0;
      else
         rx_valid <= cs_q & ~cs & (cnt_q == CW'(BITS));
   end

   // ---------------------------------------------------------------
   // Transmit: word frozen at select, one bit per rising edge
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tx_q <= '0;
         sdo  <= 1'b0;
      end
      else if (cs & ~cs_q)
         tx_q <= tx_word;
      else if (cs & rise)
      begin
         sdo  <= tx_q[BITS-1];
         tx_q <= {tx_q[BITS-2:0], 1'b0};
      end
   end
endmodule
`default_nettype wire

// *** test/three_phase_gate_predriver_logic_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tpg_cfg.svh"
module three_phase_gate_predriver_logic_tb_top;
   logic        clk, rst_n, por_ok, oc, wr, rd, pd, vr, hz;
   logic [2:0]  pos, gh, gl;
   logic [6:0]  flt;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, v;
   int          n_mismatch, compares;
   tpg_if lk ();
   tpg_device tpg_device_inst (.clk(clk), .rst_n(rst_n), .link(lk), .por_ok(por_ok),
      .hs_src_above_half(pos), .overcurrent_in(oc), .fault_in(flt), .gate_high(gh),
      .gate_low(gl), .gate_pulldown(pd), .gate_hiz(hz), .vdd_reg_en(vr));
   tpg_host tpg_host_inst (.clk(clk), .rst_n(rst_n), .link(lk), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   tpg_assertions tpg_assertions_inst (.clk(clk), .rst_n(rst_n),
      .enable_a_in(lk.enable_a_in), .enable_b_in(lk.enable_b_in),
      .dev_reset_n(lk.dev_reset_n), .phase_a_high_req_n(lk.phase_a_high_req_n),
      .cs_n(lk.cs_n), .sdo_oe_n(lk.sdo_oe_n), .interrupt_out(lk.interrupt_out),
      .gate_high(gh), .gate_low(gl));
   always #2 clk = ~clk;
   task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
      compares++;
      n_mismatch += int'(seen !== exp);
      if (seen !== exp)
         $display("BAD %s exp %h seen %h", s, exp, seen);
   endtask
   task automatic wreg(logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   // Busy is polled: frame length follows the serial clock divider
   task automatic frame(logic [3:0] op, logic [7:0] a);
      wreg(`TPG_H_TX, {16'h0, op, 4'h0, a});
      for (int i = 0; i < 2000; i++)
      begin
         rreg(`TPG_H_STAT);
         if (v[0] === 1'b0)
            break;
      end
      chk("busy", v[0], 1'b0);
   endtask
   task automatic pulse(logic [6:0] f);
      @(posedge clk);
      flt <= f;
      repeat (4) @(posedge clk);
      flt <= 7'h0;
      repeat (8) @(posedge clk);
   endtask
   function automatic logic [31:0] sx(logic i, logic [2:0] p);
      return {26'h0, i, i, p, 1'b0};
   endfunction
   task automatic end_of_test();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      #200000;
      n_mismatch++;
      end_of_test();
   end
   initial
   begin
      {clk, rst_n, por_ok, oc, wr, rd, pos, flt, addr, wdata} = '0;
      n_mismatch = 0;
      compares = 0;
      void'($urandom(65856));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      por_ok <= 1'b1;
      wreg(`TPG_H_CTRL, 32'h7);
      wreg(`TPG_H_REQ, 32'h8);
      wreg(`TPG_H_REQ, 32'h1);
      repeat (12) @(posedge clk);
      chk("dt", {gh, gl}, 6'h00);
      repeat (48) @(posedge clk);
      chk("hs", {gh, gl}, 6'h08);
      wreg(`TPG_H_CTRL, 32'h6);
      #1 chk("en", {gh, gl}, 6'h00);
      $display("gates done");
      @(posedge clk);
      oc <= 1'($urandom);
      pos <= 3'($urandom);
      repeat (8) @(posedge clk);
      rreg(`TPG_H_STAT);
      chk("st", v, sx(oc, pos));
      @(posedge clk);
      oc <= 1'b0;
      frame(`TPG_OP_CLR_INT, 8'h00);
      chk("cl", lk.interrupt_out, 1'b0);
      rreg(`TPG_H_RX);
      chk("rx", v[2:0], pos);
      frame(`TPG_OP_MODE, 8'h01);
      frame(`TPG_OP_MODE, 8'h00);
      frame(`TPG_OP_STATUS, 8'h00);
      rreg(`TPG_H_RX);
      chk("md", v[7:6], 2'b11);
      pulse(7'h01 << ($urandom % 7));
      chk("in", lk.interrupt_out, 1'b1);
      frame(`TPG_OP_MASK_LO, 8'h00);
      frame(`TPG_OP_CLR_INT, 8'h00);
      pulse(7'h01);
      chk("ml", lk.interrupt_out, 1'b0);
      pulse(7'h40);
      chk("mh", lk.interrupt_out, 1'b1);
      frame(`TPG_OP_MASK_HI, 8'h00);
      frame(`TPG_OP_CLR_INT, 8'h00);
      pulse(7'h40);
      chk("mk", lk.interrupt_out, 1'b0);
      wreg(`TPG_H_CTRL, 32'h2);
      #1 chk("pd", {pd, vr, gh, gl}, 8'h80);
      wreg(`TPG_H_CTRL, 32'h7);
      @(posedge clk);
      chk("rs", lk.interrupt_out, 1'b0);
      pulse(7'h01);
      chk("df", {lk.interrupt_out, gh}, 4'h8);
      frame(`TPG_OP_DEADTIME, 8'h00);
      wreg(`TPG_H_REQ, 32'h8);
      wreg(`TPG_H_REQ, 32'h1);
      repeat (12) @(posedge clk);
      chk("d0", {gh, gl}, 6'h08);
      por_ok <= 1'b0;
      @(posedge clk);
      #1 chk("po", {hz, lk.interrupt_out, gh, gl}, 8'h80);
      $display("faults done");
      end_of_test();
   end
endmodule
`default_nettype wire

// *** test/tpg_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module tpg_assertions (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       enable_a_in,
   input wire logic       enable_b_in,
   input wire logic       dev_reset_n,
   input wire logic       phase_a_high_req_n,
   input wire logic       cs_n,
   input wire logic       sdo_oe_n,
   input wire logic       interrupt_out,
   input wire logic [2:0] gate_high,
   input wire logic [2:0] gate_low
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_hi;
      phase_a_high_req_n [*4];
   endsequence
   sequence s_sel;
      (!cs_n && dev_reset_n) [*4];
   endsequence
   property p_en; !(enable_a_in && enable_b_in) |-> (gate_high | gate_low) == 3'h0; endproperty
   a_en: assert property (p_en) else $error("gate on");
   property p_rst; !dev_reset_n |-> (gate_high | gate_low) == 3'h0; endproperty
   a_rst: assert property (p_rst) else $error("gate in reset");
   property p_xc; (gate_high & gate_low) == 3'h0; endproperty
   a_xc: assert property (p_xc) else $error("both on");
   property p_hi; s_hi |-> !gate_high[0]; endproperty
   a_hi: assert property (p_hi) else $error("high idle");
   property p_hiz; cs_n [*4] |-> sdo_oe_n; endproperty
   a_hiz: assert property (p_hiz) else $error("sdo driven");
   property p_sel; s_sel |-> !sdo_oe_n; endproperty
   a_sel: assert property (p_sel) else $error("sdo off");
   property p_ih; interrupt_out && !cs_n |=> interrupt_out || !dev_reset_n; endproperty
   a_ih: assert property (p_ih) else $error("int dropped");
   property p_ir; $rose(dev_reset_n) |-> ##1 !interrupt_out; endproperty
   a_ir: assert property (p_ir) else $error("int at reset");
endmodule
`default_nettype wire
